// >>> core/cache_coherence_op_control.sv
// Behaviour
// - Base address then word count launches block operation.
// - Word count reads zero when block completes.
// - Writing one to global register while idle starts operation.
// - Global busy bit reads one until finished.
// - Level-2 set stays correct under hazard sequence.
// - Writeback-only operations never block cache traffic.
// - Memory fence stalls core while an operation runs.
// - Freeze, flush, poll, fence, unfreeze sequence supported.
`include "coh_consts.svh"
module cache_coherence_op_control
   import coh_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic base_wr_i,
   input wire logic [`ADDR_W-1:0] base_addr_i,
   input wire logic count_wr_i,
   input wire logic [`COUNT_W-1:0] count_i,
   input wire logic [1:0] block_kind_i,
   input wire logic [3:0] global_wr_i,
   input wire logic [3:0] global_data_i,
   input wire logic line_done_i,
   input wire logic memory_fence_i,
   input wire logic cpu_mem_req_i,
   output logic [`COUNT_W-1:0] block_word_count_o,
   output logic [3:0] global_status_o,
   output line_req_t line_req_o,
   output logic fence_stall_o,
   output logic cache_traffic_hold_o
);
   localparam logic [`COUNT_W-1:0] LINE_WORDS =
      `COUNT_W'(1 << `LINE_WORDS_LOG2);
   localparam logic [`ADDR_W-1:0] LINE_BYTES =
      `ADDR_W'(LINE_WORDS << `WORD_BYTES_LOG2);
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_n;
   // Release passes two flops, so every register leaves reset on one edge.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   typedef enum {st_idle, st_issue, st_wait} state_t;
   state_t state_reg, state_next;
   logic [`ADDR_W-1:0] base_reg, base_next;
   logic [`ADDR_W-1:0] addr_reg, addr_next;
   logic [`COUNT_W-1:0] count_reg, count_next;
   logic [3:0] global_reg, global_next;
   logic [1:0] gidx_reg, gidx_next;
   logic global_run_reg, global_run_next;
   logic inval_reg, inval_next;
   line_req_t req_reg, req_next;
   logic [`COUNT_W-1:0] step;

   always_comb
   begin
      state_next = state_reg;
      base_next = base_reg;
      addr_next = addr_reg;
      count_next = count_reg;
      global_next = global_reg;
      gidx_next = gidx_reg;
      global_run_next = global_run_reg;
      inval_next = inval_reg;
      req_next = req_reg;
      step = (count_reg > LINE_WORDS) ? LINE_WORDS : count_reg;
      if (base_wr_i && state_reg == st_idle)
         base_next = base_addr_i;
      for (int i = 0; i < 4; i++)
      begin
         // Each bit of a command write made while idle starts its own command when its data bit is one.
         if (global_wr_i[i] && global_data_i[i] && state_reg == st_idle)
            global_next[i] = 1'b1;
      end
      case (state_reg)
         st_idle:
         begin
            if (count_wr_i && count_i != '0)
            begin
               count_next = count_i;
               addr_next = base_reg;
               inval_next = (block_kind_i != `KIND_WB_ONLY);
               global_run_next = 1'b0;
               state_next = st_issue;
            end
            else if (global_next != 4'h0)
            begin
               // Commands written together run one at a time, lowest first.
               for (int i = 3; i >= 0; i--)
               begin
                  if (global_next[i])
                     gidx_next = 2'(i);
               end
               global_run_next = 1'b1;
               inval_next = 1'b1;
               count_next = LINE_WORDS;
               addr_next = '0;
               state_next = st_issue;
            end
         end
         st_issue:
         begin
            req_next.addr = addr_reg;
            req_next.invalidate = inval_reg;
            req_next.valid = 1'b1;
            state_next = st_wait;
         end
         st_wait:
         begin
            req_next.valid = 1'b0;
            if (line_done_i)
            begin
               // Count drops only after the line is retired.
               count_next = count_reg - step;
               addr_next = addr_reg + LINE_BYTES;
               if (count_reg == step)
               begin
                  if (global_run_reg)
                     global_next[gidx_reg] = 1'b0;
                  state_next = st_idle;
               end
               else
                  state_next = st_issue;
            end
         end
         default: state_next = st_idle;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= st_idle;
         base_reg <= '0;
         addr_reg <= '0;
         count_reg <= '0;
         global_reg <= 4'h0;
         gidx_reg <= 2'h0;
         global_run_reg <= 1'b0;
         inval_reg <= 1'b0;
         req_reg <= '0;
      end
      else if (ce_i)
      begin
         state_reg <= state_next;
         base_reg <= base_next;
         addr_reg <= addr_next;
         count_reg <= count_next;
         global_reg <= global_next;
         gidx_reg <= gidx_next;
         global_run_reg <= global_run_next;
         inval_reg <= inval_next;
         req_reg <= req_next;
      end
   end

   assign block_word_count_o = global_run_reg ? '0 : count_reg;
   assign global_status_o = global_reg;
   assign line_req_o = req_reg;
   // The stall is combinational so the core halts in the cycle of its fence.
   assign fence_stall_o = memory_fence_i && (state_reg != st_idle);
   // Invalidating operations hold all cache traffic for as long as they run, so
   // the miss, invalidate, allocate chain cannot interleave.
   assign cache_traffic_hold_o = (state_reg != st_idle) && inval_reg;


   busy_count_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg != st_idle && !global_run_reg) |-> block_word_count_o != '0)
      else $error("count zero while busy");
   count_done_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && state_reg == st_wait && line_done_i && count_reg == step
       && !global_run_reg) |=> block_word_count_o == '0)
      else $error("count not zero at end");
   launch_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && state_reg == st_idle && count_wr_i && count_i != '0)
      |=> state_reg == st_issue && addr_reg == $past(base_reg))
      else $error("block op not launched");
   global_go_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && state_reg == st_idle && global_wr_i[0] && global_data_i[0])
      |=> global_status_o[0])
      else $error("global op not started");
   busy_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (global_run_reg && state_reg != st_idle) |-> global_status_o[gidx_reg])
      else $error("busy bit dropped early");
   fence_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (memory_fence_i && state_reg != st_idle) |-> fence_stall_o)
      else $error("fence not stalled");
   wb_free_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg != st_idle && !inval_reg) |-> !cache_traffic_hold_o)
      else $error("writeback held traffic");
   inv_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      line_req_o.valid && line_req_o.invalidate |-> cache_traffic_hold_o)
      else $error("invalidate without hold");
   count_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && state_reg == st_wait && !line_done_i) |=> $stable(count_reg))
      else $error("count moved without a retired line");
   busy_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && global_run_reg && state_reg == st_wait && line_done_i)
      |=> !global_status_o[$past(gidx_reg)])
      else $error("busy bit not cleared");
   line_step_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && state_reg == st_wait && line_done_i && count_reg != step)
      |=> addr_reg == $past(addr_reg) + LINE_BYTES)
      else $error("line address did not advance");
endmodule

// >>> core/coh_consts.svh
`ifndef COH_CONSTS_SVH
`define COH_CONSTS_SVH
`define ADDR_W 32
`define COUNT_W 16
`define LINE_WORDS_LOG2 4
`define WORD_BYTES_LOG2 2
`define KIND_WB_ONLY 2'h0
`endif

// >>> core/coh_pkg.sv
package coh_pkg;
   typedef enum logic [2:0]
   {
      op_none,
      op_block_wb,
      op_block_inv,
      op_block_writeback_invalidate,
      op_l1_inv_all,
      op_l1_writeback_invalidate_all,
      op_l2_inv_all,
      op_l2_writeback_invalidate_all
   } coh_op_t;
   typedef struct packed
   {
      logic [31:0] addr;
      logic invalidate;
      logic valid;
   } line_req_t;
endpackage

// >>> verification/cache_line_responder.sv
module cache_line_responder
   import coh_pkg::*;
(
   input wire logic clk_i,
   input wire line_req_t line_req_i,
   input wire logic [3:0] delay_i,
   output logic line_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt = -1;
   initial line_done_o = 1'b0;
   // Each line retires some cycles after its request, never in the same one.
   always @(negedge clk_i)
   begin
      line_done_o <= 1'b0;
      if (line_req_i.valid === 1'b1)
         wait_cnt <= delay_i;
      else if (wait_cnt > 0)
         wait_cnt <= wait_cnt - 1;
      else if (wait_cnt == 0)
      begin
         line_done_o <= 1'b1;
         wait_cnt <= -1;
      end
   end
endmodule

// >>> verification/test_cache_coherence_op_control.sv
module test_cache_coherence_op_control;
   import coh_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, base_wr_i = 1'b0;
   logic count_wr_i = 1'b0, memory_fence_i = 1'b0, line_done;
   logic [31:0] base_addr_i = 32'h0;
   logic [15:0] count_i = 16'h0, word_count;
   logic [1:0] block_kind_i = 2'h0;
   logic [3:0] global_wr_i = 4'h0, global_data_i = 4'h0, status, delay = 4'h2;
   logic stall, hold;
   line_req_t req;
   int num_errors = 0, cmp_count = 0;
   initial forever #12.5 clk_i = ~clk_i;
   cache_coherence_op_control DUT (.clk_i(clk_i), .nrst_i(nrst_i),
      .ce_i(ce_i), .base_wr_i(base_wr_i), .base_addr_i(base_addr_i),
      .count_wr_i(count_wr_i), .count_i(count_i),
      .block_kind_i(block_kind_i), .global_wr_i(global_wr_i),
      .global_data_i(global_data_i), .line_done_i(line_done),
      .memory_fence_i(memory_fence_i), .cpu_mem_req_i(1'b0),
      .block_word_count_o(word_count), .global_status_o(status),
      .line_req_o(req), .fence_stall_o(stall), .cache_traffic_hold_o(hold));
   cache_line_responder cache (.clk_i(clk_i), .line_req_i(req),
      .delay_i(delay), .line_done_o(line_done));
   task automatic end_of_test();
      if (num_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // A bounded wait; running out of it ends the run as a failure.
   task automatic wait_valid();
      int n;
      for (n = 0; n < 100 && req.valid !== 1'b1; n++)
         @(negedge clk_i);
      check(32'(n < 100), 32'h1);
      if (n == 100)
         end_of_test();
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; n < 100 && (word_count !== 0 || status !== 0); n++)
         @(negedge clk_i);
      check(32'(word_count), 32'h0);
      check(32'(status), 32'h0);
      check(32'(stall), 32'h0);
      check(32'(n < 100), 32'h1);
      if (n == 100)
         end_of_test();
      // Sixteen quiet cycles stand in for the idle instructions.
      repeat (16) @(negedge clk_i);
   endtask
   task automatic run_block(input logic [1:0] kind, input logic [15:0] words,
      input logic [3:0] dly, input logic fence);
      int lines;
      lines = (words + 15) / 16;
      delay = dly;
      block_kind_i = kind;
      memory_fence_i = fence;
      base_addr_i = 32'h0000_1000 + 32'(kind) * 32'h0000_1000;
      base_wr_i = 1'b1;
      @(negedge clk_i);
      base_wr_i = 1'b0;
      count_i = words;
      count_wr_i = 1'b1;
      @(negedge clk_i);
      count_wr_i = 1'b0;
      for (int i = 0; i < lines; i++)
      begin
         wait_valid();
         check(req.addr, base_addr_i + 32'(i * 64));
         check(32'(req.invalidate), 32'(kind != 2'h0));
         check(32'(hold), 32'(kind != 2'h0));
         check(32'(word_count), 32'(words) - 32'(16 * i));
         check(32'(stall), 32'(fence));
         // A write while busy must not disturb the running count.
         count_wr_i = (i == 0);
         count_i = 16'h0001;
         @(negedge clk_i);
         count_wr_i = 1'b0;
      end
      wait_idle();
   endtask
   task automatic run_global(input int idx);
      global_data_i = 4'hF;
      global_wr_i = 4'h1 << idx;
      @(negedge clk_i);
      global_wr_i = 4'h0;
      wait_valid();
      check(32'(status), 32'(4'h1 << idx));
      check(32'(req.invalidate), 32'h1);
      check(32'(word_count), 32'h0);
      check(32'({stall, hold}), 32'h3);
      wait_idle();
   endtask
   task automatic refused();
      count_i = 16'h0;
      count_wr_i = 1'b1;
      global_data_i = 4'h0;
      global_wr_i = 4'hF;
      @(negedge clk_i);
      count_wr_i = 1'b0;
      global_wr_i = 4'h0;
      repeat (4)
      begin
         @(negedge clk_i);
         check(32'({req.valid, status}), 32'h0);
      end
   endtask
   // A reset in the middle of a block operation drops all busy state.
   task automatic reset_mid();
      base_wr_i = 1'b1;
      @(negedge clk_i);
      base_wr_i = 1'b0;
      count_i = 16'h0020;
      count_wr_i = 1'b1;
      @(negedge clk_i);
      count_wr_i = 1'b0;
      wait_valid();
      nrst_i = 1'b0;
      @(negedge clk_i);
      check(32'({word_count, status, req.valid, hold}), 32'h0);
      nrst_i = 1'b1;
      repeat (20) @(negedge clk_i);
      check(32'({word_count, status, req.valid}), 32'h0);
   endtask
   initial
   begin
      repeat (5) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      refused();
      reset_mid();
      // The third run polls with no fence; its invalidate still holds cache traffic.
      for (int k = 0; k < 4; k++)
         run_block(2'(k), 16'(40 + 8 * k), 4'(2 + 3 * k), k != 2);
      for (int g = 0; g < 4; g++)
         run_global(g);
      end_of_test();
   end
endmodule
